//--- design/atc_defines.svh
/*
  Constants of the transmit encoder: cell geometry, command nibbles,
  generator values, mode codes and symbol timing.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef ATC_DEFINES_SVH
`define ATC_DEFINES_SVH

`define ATC_CELL_BYTES 6'h35
`define ATC_CELL_LAST 6'h34
`define ATC_FIFO_CELLS 2'h3
`define ATC_STORE_BYTES 159
`define ATC_STORE_AW 8
`define ATC_SLOT_LAST 2'h2
`define ATC_ESC_SYM 5'h02
`define ATC_CMD_SOC 4'h4
`define ATC_CMD_MARK 4'h8
`define ATC_SCRAMBLER_SEQUENCE_GEN_INIT 10'h3FF
`define ATC_SCRAMBLER_SEQUENCE_GEN_CYCLE 10'h3FF
`define ATC_MODE_U2 2'h0
`define ATC_MODE_U1 2'h1
`define ATC_MODE_NIB 2'h2
`define ATC_SYM_LAST 3'h4
`define ATC_FIFO_WORDS 4
`define ATC_BYTE_TOKEN_W 9

`endif

//--- design/atc_fifo.sv
/*
  Small first-in first-out buffer with valid/ready on both sides.
  Assumes one clock and a depth that is a power of two.
*/
`timescale 1ns/1ps
`include "atc_defines.svh"

module atc_fifo #(
  parameter int W = `ATC_BYTE_TOKEN_W,
  parameter int D = `ATC_FIFO_WORDS
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [W-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } atc_fifo_state_t;

  atc_fifo_state_t s_q, s_d;
  logic [W-1:0] mem_q [D];
  logic push;
  logic pop;
  logic full;
  logic empty;

  // extra pointer bit tells full from empty without a counter
  assign full = (s_q.wp[AW] != s_q.rp[AW]) && (s_q.wp[AW-1:0] == s_q.rp[AW-1:0]);
  assign empty = (s_q.wp == s_q.rp);
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem_q[s_q.rp[AW-1:0]];
  assign push = in_valid_i && !full;
  assign pop = out_ready_i && !empty;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.wp = s_q.wp + 1'b1;
    end
    if (pop) begin
      s_d.rp = s_q.rp + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem_q[s_q.wp[AW-1:0]] <= in_data_i;
    end
  end

endmodule : atc_fifo

//--- design/atc_pkg.sv
/*
  Types of the transmit encoder: cell input word, byte token, transmit
  states and the packed state record of the top module.
  Assumes atc_defines.svh is on the include path.
*/
`include "atc_defines.svh"

package atc_pkg;

  typedef enum logic [1:0] {ATC_TX_IDLE, ATC_TX_CMD, ATC_TX_DATA} atc_tx_state_t;

  typedef struct packed {
    logic soc;
    logic [15:0] data;
  } atc_cell_in_t;

  typedef struct packed {
    logic soc;
    logic [7:0] data;
  } atc_byte_t;

  typedef struct packed {
    logic [1:0] mode_s1;
    logic [1:0] mode_s2;
    logic ref_s1;
    logic ref_s2;
    logic ref_s3;
    logic pend_v;
    logic [7:0] pend;
    logic half_v;
    logic half_soc;
    logic [3:0] half;
    logic wr_act;
    logic [5:0] wr_idx;
    logic [1:0] wr_slot;
    logic [1:0] cells;
    logic [1:0] rd_slot;
    logic [5:0] rd_idx;
    logic lo;
    atc_tx_state_t st;
    logic in_cell;
    logic [3:0] cmd;
    logic cmd_esc;
    logic mark_pend;
    logic prev_esc;
    logic first;
    logic [9:0] scrambler_sequence_gen;
    logic [9:0] cyc;
    logic [2:0] bit_cnt;
    logic [4:0] shreg;
    logic line;
  } atc_state_t;

endpackage : atc_pkg

//--- design/atc_tx_encoder.sv
/*
  Transmit convergence path of one line port: cell interface assembly,
  three-cell store, command bytes, nibble scrambler, 4b/5b and NRZI.
  Assumes cells arrive on ref_clk_i; mode and timing reference are pins.
*/
`timescale 1ns/1ps
`include "atc_defines.svh"

// Function
// - command byte precedes every 53-byte cell
// - escape-escape starts cell, resets generators
// - escape-4 starts cell, generator keeps running
// - timing marker sent at once, octet boundary
// - cell bytes contiguous apart from marker
// - three-cell store, send only whole cells
// - nibbles to scrambler, high nibble first
// - xor data nibble with generator top bits
// - generator advances four bits per nibble
// - step every nibble, scramble only data
// - resetting command only after full cycle
// - first cell after power-on uses reset
// - consecutive escape pairs reset on last pair
// - encode x0 column of nibbles
// - encode x1 column of nibbles
// - encode x2 column of nibbles
// - encode x3 column of nibbles
// - seventeen symbols, escape is 00010
// - NRZI code the serial symbol stream
// - mode pins select cell interface width
// - toggle on one, symbol MSB first
// - idle keeps sending symbols, no new command
module atc_tx_encoder (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [1:0] mode_sel_i,
  input wire logic tx_timing_ref_in_i,
  input wire atc_pkg::atc_cell_in_t cell_in_i,
  input wire logic cell_valid_i,
  output logic cell_ready_o,
  output logic line_tx_o
);

  atc_pkg::atc_state_t s_q, s_d;
  logic [7:0] mem_q [`ATC_STORE_BYTES];
  atc_pkg::atc_byte_t fin_data;
  atc_pkg::atc_byte_t fout_data;
  logic fin_valid;
  logic fin_ready;
  logic fout_valid;
  logic fout_ready;
  logic wr_en;
  logic [`ATC_STORE_AW-1:0] wr_addr;
  logic cell_done;
  logic cell_sent;
  logic fall;
  logic ld;
  logic esc;
  logic [3:0] nib;
  logic [4:0] sym;

  function automatic logic [4:0] enc5(input logic [3:0] n);
    logic [4:0] r;
    r = 5'h00;
    unique case (n)
      4'h0: r = 5'h15;
      4'h4: r = 5'h07;
      4'h8: r = 5'h12;
      4'hC: r = 5'h17;
      4'h1: r = 5'h09;
      4'h5: r = 5'h0D;
      4'h9: r = 5'h19;
      4'hD: r = 5'h1D;
      4'h2: r = 5'h0A;
      4'h6: r = 5'h0E;
      4'hA: r = 5'h1A;
      4'hE: r = 5'h1E;
      4'h3: r = 5'h0B;
      4'h7: r = 5'h0F;
      4'hB: r = 5'h1B;
      4'hF: r = 5'h1F;
    endcase
    return r;
  endfunction : enc5

  // four single-bit shifts of x^10 + x^7 + 1 per nibble
  function automatic logic [9:0] step4(input logic [9:0] p);
    logic [9:0] r;
    r = p;
    for (int k = 0; k < 4; k++) begin
      r = {r[8:0], r[9] ^ r[6]};
    end
    return r;
  endfunction : step4

  function automatic logic [1:0] slot_next(input logic [1:0] s);
    return (s == `ATC_SLOT_LAST) ? 2'h0 : 2'(s + 2'h1);
  endfunction : slot_next

  function automatic logic [`ATC_STORE_AW-1:0] addr(input logic [1:0] s, input logic [5:0] i);
    // widen first: slot base plus index overflows six bits
    return `ATC_STORE_AW'(s) * `ATC_STORE_AW'(`ATC_CELL_BYTES) + `ATC_STORE_AW'(i);
  endfunction : addr

  // byte tokens cross a small buffer so the store side can stall the input
  atc_fifo #(
    .W(`ATC_BYTE_TOKEN_W),
    .D(`ATC_FIFO_WORDS)
  ) u_in_fifo (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .in_data_i(fin_data),
    .in_valid_i(fin_valid),
    .in_ready_o(fin_ready),
    .out_data_o(fout_data),
    .out_valid_o(fout_valid),
    .out_ready_i(fout_ready)
  );

  always_comb begin
    logic [5:0] idx;
    logic [7:0] rbyte;
    logic xx;
    idx = 6'h00;
    rbyte = 8'h00;
    xx = 1'b0;
    s_d = s_q;
    esc = 1'b0;
    nib = 4'h0;
    sym = 5'h00;
    cell_done = 1'b0;
    cell_sent = 1'b0;
    // pins pass two flops before use
    s_d.mode_s1 = mode_sel_i;
    s_d.mode_s2 = s_q.mode_s1;
    s_d.ref_s1 = tx_timing_ref_in_i;
    s_d.ref_s2 = s_q.ref_s1;
    s_d.ref_s3 = s_q.ref_s2;
    fall = s_q.ref_s3 && !s_q.ref_s2;

    // cell interface: split words or join nibbles into byte tokens
    cell_ready_o = 1'b0;
    fin_valid = 1'b0;
    fin_data = '0;
    if (s_q.pend_v) begin
      fin_valid = 1'b1;
      fin_data.data = s_q.pend;
      if (fin_ready) begin
        s_d.pend_v = 1'b0;
      end
    end else begin
      unique case (s_q.mode_s2)
        `ATC_MODE_U2: begin
          cell_ready_o = fin_ready;
          fin_valid = cell_valid_i;
          fin_data.soc = cell_in_i.soc;
          fin_data.data = cell_in_i.data[15:8];
          if (cell_valid_i && fin_ready) begin
            s_d.pend_v = 1'b1;
            s_d.pend = cell_in_i.data[7:0];
          end
        end
        `ATC_MODE_U1: begin
          cell_ready_o = fin_ready;
          fin_valid = cell_valid_i;
          fin_data.soc = cell_in_i.soc;
          fin_data.data = cell_in_i.data[7:0];
        end
        `ATC_MODE_NIB: begin
          if (s_q.half_v) begin
            cell_ready_o = fin_ready;
            fin_valid = cell_valid_i;
            fin_data.soc = s_q.half_soc;
            fin_data.data = {s_q.half, cell_in_i.data[3:0]};
            if (cell_valid_i && fin_ready) begin
              s_d.half_v = 1'b0;
            end
          end else begin
            cell_ready_o = 1'b1;
            if (cell_valid_i) begin
              s_d.half_v = 1'b1;
              s_d.half = cell_in_i.data[3:0];
              s_d.half_soc = cell_in_i.soc;
            end
          end
        end
        default: begin
          // reserved pin code: input held off
          cell_ready_o = 1'b0;
        end
      endcase
    end

    // store writer; a slot is free while fewer than three cells are whole
    fout_ready = (s_q.cells != `ATC_FIFO_CELLS);
    wr_en = 1'b0;
    wr_addr = '0;
    if (fout_valid && fout_ready && (fout_data.soc || s_q.wr_act)) begin
      idx = fout_data.soc ? 6'h00 : s_q.wr_idx;
      wr_en = 1'b1;
      wr_addr = addr(s_q.wr_slot, idx);
      s_d.wr_act = 1'b1;
      s_d.wr_idx = 6'(idx + 6'h01);
      if (idx == `ATC_CELL_LAST) begin
        s_d.wr_act = 1'b0;
        s_d.wr_slot = slot_next(s_q.wr_slot);
        cell_done = 1'b1;
      end
    end

    // serializer with NRZI: a one toggles the line, MSB leaves first
    ld = (s_q.bit_cnt == `ATC_SYM_LAST);
    s_d.line = s_q.line ^ s_q.shreg[4];
    s_d.shreg = {s_q.shreg[3:0], 1'b0};
    s_d.bit_cnt = 3'(s_q.bit_cnt + 3'h1);
    s_d.mark_pend = s_q.mark_pend || fall;
    rbyte = mem_q[addr(s_q.rd_slot, s_q.rd_idx)];

    if (ld) begin
      s_d.bit_cnt = 3'h0;
      unique case (s_q.st)
        atc_pkg::ATC_TX_IDLE, atc_pkg::ATC_TX_DATA: begin
          if (s_q.mark_pend && (s_q.st == atc_pkg::ATC_TX_IDLE || !s_q.lo)) begin
            // marker wins at the next octet boundary; a new edge is kept
            esc = 1'b1;
            s_d.cmd = `ATC_CMD_MARK;
            s_d.cmd_esc = 1'b0;
            s_d.mark_pend = fall;
            s_d.st = atc_pkg::ATC_TX_CMD;
          end else if (s_q.st == atc_pkg::ATC_TX_IDLE && s_q.cells != 2'h0) begin
            xx = s_q.first || (s_q.cyc == `ATC_SCRAMBLER_SEQUENCE_GEN_CYCLE);
            esc = 1'b1;
            s_d.cmd = `ATC_CMD_SOC;
            s_d.cmd_esc = xx;
            if (xx) begin
              s_d.first = 1'b0;
            end
            s_d.st = atc_pkg::ATC_TX_CMD;
          end else if (s_q.st == atc_pkg::ATC_TX_DATA) begin
            nib = (s_q.lo ? rbyte[3:0] : rbyte[7:4]) ^ s_q.scrambler_sequence_gen[9:6];
            s_d.lo = !s_q.lo;
            if (s_q.lo) begin
              s_d.rd_idx = 6'(s_q.rd_idx + 6'h01);
              if (s_q.rd_idx == `ATC_CELL_LAST) begin
                cell_sent = 1'b1;
                s_d.rd_slot = slot_next(s_q.rd_slot);
                s_d.in_cell = 1'b0;
                s_d.st = atc_pkg::ATC_TX_IDLE;
              end
            end
          end else begin
            // keep the line busy with scrambled filler, no command
            nib = s_q.scrambler_sequence_gen[9:6];
          end
        end
        atc_pkg::ATC_TX_CMD: begin
          esc = s_q.cmd_esc;
          nib = s_q.cmd;
          if (s_q.cmd == `ATC_CMD_MARK) begin
            s_d.st = s_q.in_cell ? atc_pkg::ATC_TX_DATA : atc_pkg::ATC_TX_IDLE;
          end else begin
            s_d.st = atc_pkg::ATC_TX_DATA;
            s_d.in_cell = 1'b1;
            s_d.rd_idx = 6'h00;
            s_d.lo = 1'b0;
          end
        end
        default: begin
          s_d.st = atc_pkg::ATC_TX_IDLE;
        end
      endcase
      sym = esc ? `ATC_ESC_SYM : enc5(nib);
      s_d.shreg = sym;
      s_d.prev_esc = esc;
      if (esc && s_q.prev_esc) begin
        // second escape of a pair: next nibble meets all-ones
        s_d.scrambler_sequence_gen = `ATC_SCRAMBLER_SEQUENCE_GEN_INIT;
        s_d.cyc = 10'h000;
      end else begin
        s_d.scrambler_sequence_gen = step4(s_q.scrambler_sequence_gen);
        if (s_q.cyc != `ATC_SCRAMBLER_SEQUENCE_GEN_CYCLE) begin
          s_d.cyc = 10'(s_q.cyc + 10'h001);
        end
      end
    end

    s_d.cells = 2'(s_q.cells + {1'b0, cell_done} - {1'b0, cell_sent});
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.first <= 1'b1;
      s_q.scrambler_sequence_gen <= `ATC_SCRAMBLER_SEQUENCE_GEN_INIT;
      s_q.ref_s1 <= 1'b1;
      s_q.ref_s2 <= 1'b1;
      s_q.ref_s3 <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (wr_en) begin
      mem_q[wr_addr] <= fout_data.data;
    end
  end

  assign line_tx_o = s_q.line;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  line_toggle_a: assert property (s_q.shreg[4] |=> s_q.line != $past(s_q.line))
    else $error("line did not toggle for a one bit");
  line_hold_a: assert property (!s_q.shreg[4] |=> $stable(s_q.line))
    else $error("line toggled for a zero bit");
  store_bound_a: assert property (s_q.cells == `ATC_FIFO_CELLS |-> !wr_en)
    else $error("store written while three cells held");
  whole_cell_a: assert property (ld && s_q.st == atc_pkg::ATC_TX_IDLE && s_q.cells == 2'h0
      |=> !(s_q.st == atc_pkg::ATC_TX_CMD && s_q.cmd == `ATC_CMD_SOC))
    else $error("cell started without a whole cell stored");
  reset_after_pair_a: assert property (ld && esc && s_q.prev_esc |=> s_q.scrambler_sequence_gen == `ATC_SCRAMBLER_SEQUENCE_GEN_INIT)
    else $error("generator not all-ones after escape pair");
  gen_step_a: assert property (ld && !(esc && s_q.prev_esc) |=> s_q.scrambler_sequence_gen == step4($past(s_q.scrambler_sequence_gen)))
    else $error("generator did not advance by one nibble");
  first_reset_a: assert property (ld && s_q.first && s_q.st == atc_pkg::ATC_TX_IDLE && s_q.cells != 2'h0
      && !s_q.mark_pend |=> s_q.cmd_esc && !s_q.first)
    else $error("first cell not preceded by resetting command");
  reset_cycle_a: assert property (ld && s_q.st == atc_pkg::ATC_TX_IDLE && s_q.cells != 2'h0 && !s_q.mark_pend
      && !s_q.first && s_q.cyc != `ATC_SCRAMBLER_SEQUENCE_GEN_CYCLE |=> !s_q.cmd_esc)
    else $error("resetting command before generator cycle done");
  marker_prompt_a: assert property ($rose(s_q.mark_pend) |-> ##[1:16] (s_q.st == atc_pkg::ATC_TX_CMD
      && s_q.cmd == `ATC_CMD_MARK))
    else $error("timing marker not inserted in time");
  cmd_clear_a: assert property (ld && s_q.st == atc_pkg::ATC_TX_CMD && !s_q.cmd_esc
      |=> s_q.shreg == enc5($past(s_q.cmd)))
    else $error("command nibble was scrambled");
  byte_order_a: assert property (ld && s_q.st == atc_pkg::ATC_TX_DATA && !s_q.mark_pend && !s_q.lo
      |=> s_q.lo && s_q.st == atc_pkg::ATC_TX_DATA)
    else $error("low nibble did not follow high nibble");

  xx_sent_c: cover property (ld && s_q.st == atc_pkg::ATC_TX_CMD && s_q.cmd_esc);
  x4_sent_c: cover property (ld && s_q.st == atc_pkg::ATC_TX_CMD && !s_q.cmd_esc && s_q.cmd == `ATC_CMD_SOC);
  marker_in_cell_c: cover property (ld && s_q.in_cell && s_q.st == atc_pkg::ATC_TX_CMD);
  store_full_c: cover property (s_q.cells == `ATC_FIFO_CELLS && fout_valid);

endmodule : atc_tx_encoder

//--- verif/atc_line_rx.sv
/*
  Far-end receiver model: NRZI decode, symbol lock on the escape symbol,
  5b/4b decode, command bytes, descrambler and capture of cell bytes.
  Assumes one line bit per rising edge of ref_clk_i, reset to a low line.
*/
`timescale 1ns/1ps
`include "atc_defines.svh"

module atc_line_rx (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic line_i
);
  localparam logic [4:0] SYM [16] = '{5'h15, 5'h09, 5'h0A, 5'h0B, 5'h07, 5'h0D, 5'h0E, 5'h0F,
    5'h12, 5'h19, 5'h1A, 5'h1B, 5'h17, 5'h1D, 5'h1E, 5'h1F};
  logic prev;
  logic pesc;
  logic cwait;
  logic lock;
  logic [4:0] win;
  logic [9:0] scrambler_sequence_gen;
  logic [3:0] hi;
  int ph;
  int nleft;
  int soc_xx = 0;
  int soc_x4 = 0;
  int marks = 0;
  int bad = 0;
  int toggles = 0;
  int mark_odd = 0;
  int cut = 0;
  logic [7:0] rxq [$];

  function automatic logic [9:0] step4(input logic [9:0] p);
    for (int i = 0; i < 4; i++) begin
      p = {p[8:0], p[9] ^ p[6]};
    end
    return p;
  endfunction : step4

  task automatic start_cell;
    if (nleft > 0) begin
      cut++;
    end
    nleft = 106;
  endtask : start_cell

  task automatic take(input logic [4:0] s);
    logic [3:0] n;
    int v;
    v = -1;
    for (int i = 0; i < 16; i++) begin
      if (SYM[i] == s) v = i;
    end
    if (s == `ATC_ESC_SYM) begin
      scrambler_sequence_gen = pesc ? `ATC_SCRAMBLER_SEQUENCE_GEN_INIT : step4(scrambler_sequence_gen);
      if (cwait) begin
        soc_xx++;
        start_cell();
      end
      cwait = !cwait;
      pesc = 1'b1;
    end else begin
      if (v < 0) bad++;
      n = v[3:0];
      if (cwait) begin
        if (n == `ATC_CMD_SOC) begin
          soc_x4++;
          start_cell();
        end else if (n == `ATC_CMD_MARK) begin
          marks++;
          mark_odd += nleft % 2;
        end else begin
          bad++;
        end
      end else if (nleft > 0) begin
        n = n ^ scrambler_sequence_gen[9:6];
        if (nleft % 2 == 0) hi = n;
        else rxq.push_back({hi, n});
        nleft--;
      end
      scrambler_sequence_gen = step4(scrambler_sequence_gen);
      cwait = 1'b0;
      pesc = 1'b0;
    end
  endtask : take

  // escape cannot appear across a symbol boundary, so it is a safe lock point
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev = 1'b0;
      win = 5'h00;
      ph = 0;
      lock = 1'b0;
      pesc = 1'b0;
      cwait = 1'b0;
      nleft = 0;
      scrambler_sequence_gen = `ATC_SCRAMBLER_SEQUENCE_GEN_INIT;
    end else begin
      if (line_i !== prev) toggles++;
      win = {win[3:0], line_i ^ prev};
      prev = line_i;
      ph++;
      if (win == `ATC_ESC_SYM) begin
        lock = 1'b1;
        ph = 5;
      end
      if (lock && ph == 5) begin
        ph = 0;
        take(win);
      end
    end
  end
endmodule : atc_line_rx

//--- verif/tb_atc_tx_encoder.sv
/*
  Self-checking bench of the transmit encoder: cells in every interface
  mode, partial cells, back-pressure, idle line and timing requests.
  Assumes the design package and the line receiver model are compiled first.
*/
`timescale 1ns/1ps
`include "atc_defines.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module tb_atc_tx_encoder;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [1:0] mode_sel_i = `ATC_MODE_U1;
  logic tx_timing_ref_in_i = 1'b1;
  atc_pkg::atc_cell_in_t cell_in_i = '0;
  logic cell_valid_i = 1'b0;
  logic cell_ready_o;
  logic line_tx_o;
  int compares = 0;
  int miscompares = 0;
  int low_rdy = 0;

  always #2 ref_clk_i = ~ref_clk_i;

  atc_tx_encoder i_dut (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .mode_sel_i(mode_sel_i),
    .tx_timing_ref_in_i(tx_timing_ref_in_i),
    .cell_in_i(cell_in_i),
    .cell_valid_i(cell_valid_i),
    .cell_ready_o(cell_ready_o),
    .line_tx_o(line_tx_o)
  );

  atc_line_rx i_rx (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .line_i(line_tx_o)
  );

  function automatic logic [7:0] bval(input logic [7:0] seed, input int i);
    return seed + 8'(i) * 8'h07;
  endfunction : bval

  // request held from a falling edge until a rising edge that sees ready
  task automatic send_cell(input logic [1:0] m, input logic [7:0] seed, input int lo, input int hi);
    int k;
    int g;
    logic rdy;
    logic [7:0] b;
    k = lo;
    g = 0;
    while (k < hi && g < 5000) begin
      @(negedge ref_clk_i);
      b = bval(seed, (m == `ATC_MODE_NIB) ? k / 2 : k);
      cell_in_i.soc = (k == 0);
      if (m == `ATC_MODE_U2) cell_in_i.data = {bval(seed, 2 * k), bval(seed, 2 * k + 1)};
      else if (m == `ATC_MODE_U1) cell_in_i.data = {8'h00, b};
      else cell_in_i.data = {12'h000, k[0] ? b[3:0] : b[7:4]};
      cell_valid_i = 1'b1;
      #1 rdy = cell_ready_o;
      low_rdy += !rdy;
      @(posedge ref_clk_i);
      k += rdy;
      g++;
    end
    @(negedge ref_clk_i);
    cell_valid_i = 1'b0;
  endtask : send_cell

  task automatic send_all(input logic [1:0] m, input logic [7:0] seed);
    send_cell(m, seed, 0, (m == `ATC_MODE_U2) ? 27 : (m == `ATC_MODE_U1) ? 53 : 106);
  endtask : send_all

  task automatic check_cell(input logic [7:0] seed);
    int g;
    logic [7:0] b;
    g = 0;
    while (i_rx.rxq.size() < 53 && g < 3000) begin
      @(negedge ref_clk_i);
      g++;
    end
    for (int i = 0; i < 53; i++) begin
      b = (i_rx.rxq.size() > 0) ? i_rx.rxq.pop_front() : 8'hXX;
      `CHK(b, bval(seed, i));
    end
  endtask : check_cell

  task automatic marker;
    int g;
    int n0;
    n0 = i_rx.marks;
    @(negedge ref_clk_i);
    tx_timing_ref_in_i = 1'b0;
    g = 0;
    while (i_rx.marks == n0 && g < 50) begin
      @(negedge ref_clk_i);
      g++;
    end
    `CHK(i_rx.marks, n0 + 1);
    tx_timing_ref_in_i = 1'b1;
  endtask : marker

  task automatic t_start;
    repeat (200) @(negedge ref_clk_i);
    `CHK(i_rx.toggles > 0, 1'b1);
    `CHK(i_rx.soc_xx + i_rx.soc_x4, 0);
    send_all(`ATC_MODE_U1, 8'h10);
    send_all(`ATC_MODE_U1, 8'h20);
    check_cell(8'h10);
    check_cell(8'h20);
    `CHK(i_rx.soc_xx, 1);
    `CHK(i_rx.soc_x4, 1);
  endtask : t_start

  task automatic t_partial;
    int n0;
    n0 = i_rx.soc_xx + i_rx.soc_x4;
    send_cell(`ATC_MODE_U1, 8'h30, 0, 20);
    repeat (400) @(negedge ref_clk_i);
    `CHK(i_rx.soc_xx + i_rx.soc_x4, n0);
    send_cell(`ATC_MODE_U1, 8'h30, 20, 53);
    check_cell(8'h30);
  endtask : t_partial

  // line drains far slower than cells arrive, so the store must refuse
  task automatic t_fill;
    low_rdy = 0;
    for (int i = 0; i < 4; i++) send_all(`ATC_MODE_U1, 8'h40 + 8'(i));
    `CHK(low_rdy > 0, 1'b1);
    for (int i = 0; i < 4; i++) check_cell(8'h40 + 8'(i));
  endtask : t_fill

  task automatic t_idle;
    int t0;
    int s0;
    int s1;
    t0 = i_rx.toggles;
    s0 = i_rx.soc_xx;
    s1 = i_rx.soc_x4;
    repeat (6000) @(negedge ref_clk_i);
    `CHK(i_rx.toggles > t0, 1'b1);
    `CHK(i_rx.soc_xx + i_rx.soc_x4, s0 + s1);
    send_all(`ATC_MODE_U1, 8'h50);
    send_all(`ATC_MODE_U1, 8'h51);
    check_cell(8'h50);
    check_cell(8'h51);
    `CHK(i_rx.soc_xx, s0 + 1);
    `CHK(i_rx.soc_x4, s1 + 1);
  endtask : t_idle

  task automatic t_mark;
    int g;
    send_all(`ATC_MODE_U1, 8'h60);
    g = 0;
    while (!(i_rx.nleft > 0 && i_rx.nleft < 60) && g < 3000) begin
      @(negedge ref_clk_i);
      g++;
    end
    marker();
    check_cell(8'h60);
    `CHK(i_rx.mark_odd, 0);
    `CHK(i_rx.cut, 0);
    marker();
  endtask : t_mark

  task automatic t_modes;
    logic [1:0] m;
    for (int i = 0; i < 2; i++) begin
      m = i ? `ATC_MODE_NIB : `ATC_MODE_U2;
      @(negedge ref_clk_i);
      mode_sel_i = m;
      repeat (4) @(negedge ref_clk_i);
      send_all(m, 8'h70 + 8'(i));
      check_cell(8'h70 + 8'(i));
    end
    @(negedge ref_clk_i);
    mode_sel_i = 2'h3;
    repeat (4) @(negedge ref_clk_i);
    cell_in_i.soc = 1'b1;
    cell_valid_i = 1'b1;
    repeat (8) begin
      @(negedge ref_clk_i);
      `CHK(cell_ready_o, 1'b0);
    end
    cell_valid_i = 1'b0;
    mode_sel_i = `ATC_MODE_U1;
    `CHK(i_rx.bad, 0);
  endtask : t_modes

  task automatic results;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  initial begin
    repeat (20) @(negedge ref_clk_i);
    rst_i = 1'b0;
    repeat (3) @(negedge ref_clk_i);
    t_start();
    t_partial();
    t_fill();
    t_idle();
    t_mark();
    t_modes();
    results();
  end

  // about four times the expected run of some 14000 cycles
  initial begin
    #200000;
    miscompares++;
    results();
  end
endmodule : tb_atc_tx_encoder
